/* File: gpio_port_pkg.sv */
// How it works
// - Mode bit 16 clear selects per-bit driver
// - Mode bit 16 set selects front/back-end driver
// - Output, direction and readback registers, 32 bits
// - Direction bit 1 drives pin, 0 input
// - Phase settings go to their own unit
// - Phase is 12-bit offset-binary code
// - Attenuation is 6-bit code, 0.5 dB steps
package gpio_port_pkg;

   // ==========================================================
   // Register indices, as seen on the register port
   localparam logic [23:0] MAIN_CONTROL_ADDR           = 24'h000100;
   localparam logic [23:0] PORT_OUTPUT_VALUE_ADDR      = 24'h000138;
   localparam logic [23:0] PORT_DIRECTION_MASK_ADDR    = 24'h000139;
   localparam logic [23:0] PORT_PIN_READBACK_ADDR      = 24'h00013a;
   localparam logic [23:0] SERIAL_STATUS_ADDR          = 24'h00013b;
   localparam logic [23:0] FRONT_UNIT_PHASE_ADDR       = 24'h00013c;
   localparam logic [23:0] BACK_UNIT_PHASE_ADDR        = 24'h00013d;
   localparam logic [23:0] FRONT_UNIT_ATTENUATION_ADDR = 24'h00013e;
   localparam logic [23:0] BACK_UNIT_ATTENUATION_ADDR  = 24'h00013f;

   // ==========================================================
   // Field positions and widths
   localparam int MODE_BIT     = 16;
   localparam int PHASE_W      = 12;
   localparam int ATTEN_W      = 6;
   localparam int FRAME_W      = 16;
   localparam int NUM_SETTINGS = 4;
   localparam int STATUS_BUSY_BIT = 4;

   // Serial pin positions on the port in front/back-end mode
   localparam int PIN_SCLK        = 0;
   localparam int PIN_SDATA       = 1;
   localparam int PIN_LATCH_FRONT = 2;
   localparam int PIN_LATCH_BACK  = 3;
   localparam int SERIAL_PINS     = 4;

   // Setting index inside the pending vector
   localparam logic [1:0] SET_FRONT_PHASE = 2'h0;
   localparam logic [1:0] SET_BACK_PHASE  = 2'h1;
   localparam logic [1:0] SET_FRONT_ATTEN = 2'h2;
   localparam logic [1:0] SET_BACK_ATTEN  = 2'h3;

   // ==========================================================
   // Values after reset
   localparam logic [31:0]        MAIN_CONTROL_RESET = 32'h00000000;
   localparam logic [31:0]        PORT_OUTPUT_RESET  = 32'h00000000;
   localparam logic [31:0]        PORT_DIR_RESET     = 32'h00000000;
   localparam logic [PHASE_W-1:0] PHASE_RESET        = 12'h800;
   localparam logic [ATTEN_W-1:0] ATTEN_RESET        = 6'h00;

   // ==========================================================
   // Serial timing: one half bit of the serial clock
   localparam int CLK_HZ          = 10_000_000;
   localparam int HALF_BIT_NS     = 500;
   localparam int HALF_BIT_CYCLES = (HALF_BIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic                unit_back;
      logic                kind_atten;
      logic [PHASE_W-1:0]  value;
   } setting_req_t;

   typedef struct packed {
      logic latch_back;
      logic latch_front;
      logic sdata;
      logic sclk;
   } serial_pins_t;

endpackage : gpio_port_pkg

/* File: rf_unit_serializer.sv */
`timescale 1ns/1ps
module rf_unit_serializer
   import gpio_port_pkg::*;
(
   input  wire logic                       sys_clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       tick_i,
   input  wire logic                       start_i,
   input  wire gpio_port_pkg::setting_req_t req_i,
   output logic                            busy_o,
   output gpio_port_pkg::serial_pins_t     pins_o
);

   typedef enum logic [3:0] {
      IDLE  = 4'b0001,
      SETUP = 4'b0010,
      HIGH  = 4'b0100,
      LATCH = 4'b1000
   } ser_state_t;

   ser_state_t         state_r;
   logic [FRAME_W-1:0] shift_r;
   logic [3:0]         bit_cnt_r;
   logic               unit_back_r;

   // ==========================================================
   // Frame sequencer
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_r     <= IDLE;
         shift_r     <= '0;
         bit_cnt_r   <= 4'h0;
         unit_back_r <= 1'b0;
      end
      else
      begin
         case (state_r)
            IDLE:
            begin
               if (start_i)
               begin
                  shift_r     <= {req_i.kind_atten, 3'h0, req_i.value};
                  bit_cnt_r   <= 4'hf;
                  unit_back_r <= req_i.unit_back;
                  state_r     <= SETUP;
               end
            end
            SETUP:
            begin
               if (tick_i)
                  state_r <= HIGH;
            end
            HIGH:
            begin
               if (tick_i)
               begin
                  if (bit_cnt_r == 4'h0)
                     state_r <= LATCH;
                  else
                  begin
                     shift_r   <= {shift_r[FRAME_W-2:0], 1'b0};
                     bit_cnt_r <= bit_cnt_r - 4'h1;
                     state_r   <= SETUP;
                  end
               end
            end
            LATCH:
            begin
               if (tick_i)
                  state_r <= IDLE;
            end
            default:
               state_r <= IDLE;
         endcase
      end
   end

   // ==========================================================
   // Registered pin levels
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pins_o <= '0;
         busy_o <= 1'b0;
      end
      else
      begin
         busy_o             <= (state_r != IDLE) || start_i;
         pins_o.sclk        <= (state_r == HIGH);
         pins_o.sdata       <= (state_r == SETUP || state_r == HIGH) && shift_r[FRAME_W-1];
         pins_o.latch_front <= (state_r == LATCH) && !unit_back_r;
         pins_o.latch_back  <= (state_r == LATCH) && unit_back_r;
      end
   end

endmodule : rf_unit_serializer

/* File: dual_mode_gpio_port.sv */
// Local design decision: strobed register access.
`timescale 1ns/1ps
module dual_mode_gpio_port
   import gpio_port_pkg::*;
#(
   parameter int PORT_W = 32,
   parameter int ADDR_W = 24,
   parameter int HALF_BIT_CNT = HALF_BIT_CYCLES
)
(
   input  wire logic              sys_clk_i,
   input  wire logic              rst_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [31:0]       wr_data_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic [31:0]            rd_data_o,
   input  wire logic [PORT_W-1:0] pin_i,
   output logic [PORT_W-1:0]      pin_o,
   output logic [PORT_W-1:0]      pin_oe_o
);

   import gpio_port_pkg::*;

   // ==========================================================
   // Address match helper
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [23:0]       reg_addr);
      hit = (a == reg_addr[ADDR_W-1:0]);
   endfunction : hit

   logic [31:0]              main_control_r;
   logic [PORT_W-1:0]        port_output_value_r;
   logic [PORT_W-1:0]        port_direction_mask_r;
   logic [PORT_W-1:0]        port_pin_readback_r;
   logic [PHASE_W-1:0]       front_unit_phase_r;
   logic [PHASE_W-1:0]       back_unit_phase_r;
   logic [ATTEN_W-1:0]       front_unit_attenuation_r;
   logic [ATTEN_W-1:0]       back_unit_attenuation_r;
   logic [NUM_SETTINGS-1:0]  pending_r;
   logic [NUM_SETTINGS-1:0]  pending_set;
   logic [NUM_SETTINGS-1:0]  pending_clr;
   logic [NUM_SETTINGS-1:0]  pending_nxt;
   logic [31:0]              rd_data_nxt;
   logic [15:0]              div_cnt_r;
   logic                     tick_r;
   logic                     custom_mode;
   logic                     ser_busy;
   logic                     ser_start;
   logic [1:0]               sel_idx;
   setting_req_t             ser_req;
   serial_pins_t             ser_pins;

   assign custom_mode = main_control_r[MODE_BIT];

   // ==========================================================
   // Control and per-bit registers
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         main_control_r        <= MAIN_CONTROL_RESET;
         port_output_value_r   <= PORT_OUTPUT_RESET[PORT_W-1:0];
         port_direction_mask_r <= PORT_DIR_RESET[PORT_W-1:0];
      end
      else if (wr_i)
      begin
         if (hit(addr_i, MAIN_CONTROL_ADDR))
            main_control_r <= wr_data_i;
         else if (hit(addr_i, PORT_OUTPUT_VALUE_ADDR))
            port_output_value_r <= wr_data_i[PORT_W-1:0];
         else if (hit(addr_i, PORT_DIRECTION_MASK_ADDR))
            port_direction_mask_r <= wr_data_i[PORT_W-1:0];
      end
   end

   // ==========================================================
   // Pin readback, sampled every cycle
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         port_pin_readback_r <= '0;
      else
         port_pin_readback_r <= pin_i;
   end

   // ==========================================================
   // Front/back-end settings
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         front_unit_phase_r       <= PHASE_RESET;
         back_unit_phase_r        <= PHASE_RESET;
         front_unit_attenuation_r <= ATTEN_RESET;
         back_unit_attenuation_r  <= ATTEN_RESET;
      end
      else if (wr_i)
      begin
         if (hit(addr_i, FRONT_UNIT_PHASE_ADDR))
            front_unit_phase_r <= wr_data_i[PHASE_W-1:0];
         else if (hit(addr_i, BACK_UNIT_PHASE_ADDR))
            back_unit_phase_r <= wr_data_i[PHASE_W-1:0];
         else if (hit(addr_i, FRONT_UNIT_ATTENUATION_ADDR))
            front_unit_attenuation_r <= wr_data_i[ATTEN_W-1:0];
         else if (hit(addr_i, BACK_UNIT_ATTENUATION_ADDR))
            back_unit_attenuation_r <= wr_data_i[ATTEN_W-1:0];
      end
   end

   // ==========================================================
   // Pending updates: a new write wins over a clear
   always_comb
   begin
      pending_set = '0;
      if (wr_i)
      begin
         if (hit(addr_i, FRONT_UNIT_PHASE_ADDR))
            pending_set[SET_FRONT_PHASE] = 1'b1;
         else if (hit(addr_i, BACK_UNIT_PHASE_ADDR))
            pending_set[SET_BACK_PHASE] = 1'b1;
         else if (hit(addr_i, FRONT_UNIT_ATTENUATION_ADDR))
            pending_set[SET_FRONT_ATTEN] = 1'b1;
         else if (hit(addr_i, BACK_UNIT_ATTENUATION_ADDR))
            pending_set[SET_BACK_ATTEN] = 1'b1;
      end
      pending_clr = '0;
      if (ser_start)
         pending_clr[sel_idx] = 1'b1;
      pending_nxt = (pending_r & ~pending_clr) | pending_set;
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         pending_r <= '0;
      else
         pending_r <= pending_nxt;
   end

   // ==========================================================
   // Pick the lowest pending setting and start a frame
   always_comb
   begin
      sel_idx = SET_FRONT_PHASE;
      if (pending_r[SET_FRONT_PHASE])
         sel_idx = SET_FRONT_PHASE;
      else if (pending_r[SET_BACK_PHASE])
         sel_idx = SET_BACK_PHASE;
      else if (pending_r[SET_FRONT_ATTEN])
         sel_idx = SET_FRONT_ATTEN;
      else if (pending_r[SET_BACK_ATTEN])
         sel_idx = SET_BACK_ATTEN;
   end

   always_comb
   begin
      ser_req = '0;
      case (sel_idx)
         SET_FRONT_PHASE:
         begin
            ser_req.value = front_unit_phase_r;
         end
         SET_BACK_PHASE:
         begin
            ser_req.unit_back = 1'b1;
            ser_req.value     = back_unit_phase_r;
         end
         SET_FRONT_ATTEN:
         begin
            ser_req.kind_atten = 1'b1;
            ser_req.value      = {{(PHASE_W-ATTEN_W){1'b0}}, front_unit_attenuation_r};
         end
         default:
         begin
            ser_req.unit_back  = 1'b1;
            ser_req.kind_atten = 1'b1;
            ser_req.value      = {{(PHASE_W-ATTEN_W){1'b0}}, back_unit_attenuation_r};
         end
      endcase
   end

   assign ser_start = custom_mode && !ser_busy && (|pending_r);

   // ==========================================================
   // Half-bit enable divider
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         div_cnt_r <= 16'h0000;
         tick_r    <= 1'b0;
      end
      else if (div_cnt_r == 16'(HALF_BIT_CNT - 1))
      begin
         div_cnt_r <= 16'h0000;
         tick_r    <= 1'b1;
      end
      else
      begin
         div_cnt_r <= div_cnt_r + 16'h0001;
         tick_r    <= 1'b0;
      end
   end

   rf_unit_serializer u_serializer (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .tick_i    (tick_r),
      .start_i   (ser_start),
      .req_i     (ser_req),
      .busy_o    (ser_busy),
      .pins_o    (ser_pins)
   );

   // ==========================================================
   // Pin drivers, one per port bit
   genvar gi;
   generate
      for (gi = 0; gi < PORT_W; gi = gi + 1)
      begin : g_pin
         if (gi < SERIAL_PINS)
         begin : g_serial
            always_ff @(posedge sys_clk_i or posedge rst_i)
            begin
               if (rst_i)
               begin
                  pin_o[gi]    <= 1'b0;
                  pin_oe_o[gi] <= 1'b0;
               end
               else if (custom_mode)
               begin
                  pin_o[gi]    <= ser_pins[gi];
                  pin_oe_o[gi] <= 1'b1;
               end
               else
               begin
                  pin_o[gi]    <= port_output_value_r[gi];
                  pin_oe_o[gi] <= port_direction_mask_r[gi];
               end
            end
         end
         else
         begin : g_plain
            always_ff @(posedge sys_clk_i or posedge rst_i)
            begin
               if (rst_i)
               begin
                  pin_o[gi]    <= 1'b0;
                  pin_oe_o[gi] <= 1'b0;
               end
               else if (custom_mode)
               begin
                  pin_o[gi]    <= 1'b0;
                  pin_oe_o[gi] <= 1'b0;
               end
               else
               begin
                  pin_o[gi]    <= port_output_value_r[gi];
                  pin_oe_o[gi] <= port_direction_mask_r[gi];
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // Read port, data one cycle after the strobe
   always_comb
   begin
      rd_data_nxt = 32'h00000000;
      if (hit(addr_i, MAIN_CONTROL_ADDR))
         rd_data_nxt = main_control_r;
      else if (hit(addr_i, PORT_OUTPUT_VALUE_ADDR))
         rd_data_nxt[PORT_W-1:0] = port_output_value_r;
      else if (hit(addr_i, PORT_DIRECTION_MASK_ADDR))
         rd_data_nxt[PORT_W-1:0] = port_direction_mask_r;
      else if (hit(addr_i, PORT_PIN_READBACK_ADDR))
         rd_data_nxt[PORT_W-1:0] = port_pin_readback_r;
      else if (hit(addr_i, SERIAL_STATUS_ADDR))
      begin
         rd_data_nxt[NUM_SETTINGS-1:0] = pending_r;
         rd_data_nxt[STATUS_BUSY_BIT]  = ser_busy;
      end
      else if (hit(addr_i, FRONT_UNIT_PHASE_ADDR))
         rd_data_nxt[PHASE_W-1:0] = front_unit_phase_r;
      else if (hit(addr_i, BACK_UNIT_PHASE_ADDR))
         rd_data_nxt[PHASE_W-1:0] = back_unit_phase_r;
      else if (hit(addr_i, FRONT_UNIT_ATTENUATION_ADDR))
         rd_data_nxt[ATTEN_W-1:0] = front_unit_attenuation_r;
      else if (hit(addr_i, BACK_UNIT_ATTENUATION_ADDR))
         rd_data_nxt[ATTEN_W-1:0] = back_unit_attenuation_r;
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         rd_data_o <= 32'h00000000;
      else if (rd_i)
         rd_data_o <= rd_data_nxt;
      else
         rd_data_o <= 32'h00000000;
   end

endmodule : dual_mode_gpio_port

/* File: gpio_port_checker_assertions.sv */
`timescale 1ns/1ps
module gpio_port_checker
   import gpio_port_pkg::*;
#(
   parameter int PORT_W = 32,
   parameter int ADDR_W = 24
)
(
   input wire logic              sys_clk_i,
   input wire logic              rst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [31:0]       wr_data_i,
   input wire logic              wr_i,
   input wire logic              rd_i,
   input wire logic [31:0]       rd_data_o,
   input wire logic [PORT_W-1:0] pin_i,
   input wire logic [PORT_W-1:0] pin_o,
   input wire logic [PORT_W-1:0] pin_oe_o
);
   logic              mode_r;
   logic [PORT_W-1:0] dir_r;
   logic [PORT_W-1:0] out_r;
   logic [11:0]       fph_r;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);
   // =====
   // Shadow of written settings
   always_ff @(posedge sys_clk_i or posedge rst_i)
      if (rst_i)
      begin
         mode_r <= 1'b0;
         dir_r  <= '0;
         out_r  <= '0;
         fph_r  <= PHASE_RESET;
      end
      else if (wr_i)
      begin
         if (addr_i == MAIN_CONTROL_ADDR)
            mode_r <= wr_data_i[MODE_BIT];
         if (addr_i == PORT_DIRECTION_MASK_ADDR)
            dir_r <= wr_data_i[PORT_W-1:0];
         if (addr_i == PORT_OUTPUT_VALUE_ADDR)
            out_r <= wr_data_i[PORT_W-1:0];
         if (addr_i == FRONT_UNIT_PHASE_ADDR)
            fph_r <= wr_data_i[11:0];
      end
   // =====
   // Properties
   chk_oe_per_bit: assert property (!$past(mode_r) |-> pin_oe_o == $past(dir_r))
      else $error("enable differs from direction");
   chk_out_per_bit: assert property (!$past(mode_r) |-> pin_o == $past(out_r))
      else $error("pin value differs from output register");
   chk_oe_custom: assert property ($past(mode_r) |-> pin_oe_o == PORT_W'(4'hf))
      else $error("custom mode enables wrong");
   chk_upper_quiet: assert property ($past(mode_r) |-> pin_o[PORT_W-1:4] == '0)
      else $error("upper pins driven in custom mode");
   chk_rd_idle: assert property (!$past(rd_i) |-> rd_data_o == 32'h0)
      else $error("read data without read");
   chk_pin_readback: assert property ($past(rd_i) && !$past(rst_i, 2)
      && $past(addr_i) == PORT_PIN_READBACK_ADDR |-> rd_data_o == $past(pin_i, 2))
      else $error("readback differs from pins");
   chk_phase_read: assert property ($past(rd_i) && $past(addr_i) == FRONT_UNIT_PHASE_ADDR
      |-> rd_data_o == {20'h0, $past(fph_r)})
      else $error("front phase read wrong");
   chk_atten_width: assert property ($past(rd_i) && ($past(addr_i) == BACK_UNIT_ATTENUATION_ADDR
      || $past(addr_i) == FRONT_UNIT_ATTENUATION_ADDR) |-> rd_data_o[31:6] == '0)
      else $error("attenuation upper bits set");
   chk_latch_excl: assert property (mode_r && $past(mode_r)
      |-> !(pin_o[PIN_LATCH_FRONT] && pin_o[PIN_LATCH_BACK]))
      else $error("both latches high");
   chk_data_stable: assert property ($past(mode_r) && $past(pin_o[PIN_SCLK]) && pin_o[PIN_SCLK]
      |-> $stable(pin_o[PIN_SDATA]))
      else $error("data moved while clock high");
   cover property ($past(mode_r) && $rose(pin_o[PIN_LATCH_FRONT]));
   cover property ($past(mode_r) && $rose(pin_o[PIN_LATCH_BACK]));
   cover property ($past(rd_i) && $past(addr_i) == PORT_PIN_READBACK_ADDR);
endmodule : gpio_port_checker

/* File: rf_unit_model.sv */
`timescale 1ns/1ps
module rf_unit_model
   import gpio_port_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic [31:0] drive_val_i,
   input  wire logic [31:0] drive_en_i,
   input  wire logic [31:0] ext_i,
   output logic [31:0]      pin_level_o
);
   import gpio_port_pkg::*;
   logic [15:0] shift_r;
   logic [3:0]  prev_r;
   logic [3:0]  drv;
   logic [15:0] front_q[$];
   logic [15:0] back_q[$];
   // =====
   // Pin resolution and frame capture
   assign pin_level_o = (drive_val_i & drive_en_i) | (ext_i & ~drive_en_i);
   assign drv = drive_val_i[3:0] & drive_en_i[3:0];
   always @(posedge sys_clk_i)
   begin
      prev_r <= drv;
      if (drv[PIN_SCLK] && !prev_r[PIN_SCLK])
         shift_r <= {shift_r[14:0], drv[PIN_SDATA]};
      if (drv[PIN_LATCH_FRONT] && !prev_r[PIN_LATCH_FRONT])
         front_q.push_back(shift_r);
      if (drv[PIN_LATCH_BACK] && !prev_r[PIN_LATCH_BACK])
         back_q.push_back(shift_r);
   end
endmodule : rf_unit_model

/* File: test_dual_mode_gpio_port.sv */
`timescale 1ns/1ps
module test_dual_mode_gpio_port;
   import gpio_port_pkg::*;
   logic        sys_clk_i;
   logic        rst_i;
   logic        wr_i;
   logic        rd_i;
   logic [23:0] addr_i;
   logic [31:0] wr_data_i;
   logic [31:0] rd_data_o;
   logic [31:0] pin_i;
   logic [31:0] pin_o;
   logic [31:0] pin_oe_o;
   logic [31:0] ext_r;
   logic [31:0] seed_r;
   logic [31:0] m_out;
   logic [31:0] m_dir;
   logic [31:0] got;
   logic [11:0] m_set[4];
   int          bad_count;
   int          check_count;
   int          i;
   dual_mode_gpio_port #(.HALF_BIT_CNT(2)) dual_mode_gpio_port_i (.sys_clk_i(sys_clk_i),
      .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
      .rd_data_o(rd_data_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
   rf_unit_model rf_unit_model_i (.sys_clk_i(sys_clk_i), .drive_val_i(pin_o),
      .drive_en_i(pin_oe_o), .ext_i(ext_r), .pin_level_o(pin_i));
   // =====
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [23:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      addr_i    <= a;
      wr_data_i <= d;
      wr_i      <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rchk(input string nm, input logic [23:0] a, input logic [31:0] e);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      @(negedge sys_clk_i);
      chk(nm, e, rd_data_o);
   endtask : rchk
   task automatic wait_frames(input int n);
      for (int k = 0; k < 3000; k++)
         if (rf_unit_model_i.front_q.size() + rf_unit_model_i.back_q.size() < n)
            @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk("frames", n, rf_unit_model_i.front_q.size() + rf_unit_model_i.back_q.size());
   endtask : wait_frames
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run
   // =====
   // Clock and watchdog
   initial
   begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   initial
   begin
      repeat (30000) @(posedge sys_clk_i);
      bad_count++;
      complete_run();
   end
   // =====
   // Tests
   initial
   begin
      rst_i = 1'b1;
      {wr_i, rd_i, addr_i, wr_data_i, ext_r} = '0;
      {bad_count, check_count} = '0;
      seed_r = 32'hd722;
      m_set = '{12'h800, 12'h800, 12'h0, 12'h0};
      repeat (6) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      chk("oe_rst", 32'h0, pin_oe_o);
      rchk("ctrl", MAIN_CONTROL_ADDR, 32'h0);
      rchk("dir", PORT_DIRECTION_MASK_ADDR, 32'h0);
      for (i = 0; i < 4; i++)
         rchk("set_rst", FRONT_UNIT_PHASE_ADDR + 24'(i), {20'h0, m_set[i]});
      wr(24'h000134, 32'hffffffff);
      rchk("unmapped", 24'h000134, 32'h0);
      $display("test reset done");
      for (i = 0; i < 8; i++)
      begin
         seed_r = xs(seed_r);
         m_out = seed_r;
         seed_r = xs(seed_r);
         m_dir = seed_r;
         seed_r = xs(seed_r);
         ext_r <= seed_r;
         wr(PORT_OUTPUT_VALUE_ADDR, m_out);
         wr(PORT_DIRECTION_MASK_ADDR, m_dir);
         repeat (2) @(posedge sys_clk_i);
         rchk("readback", PORT_PIN_READBACK_ADDR, (m_out & m_dir) | (seed_r & ~m_dir));
         rchk("out_rd", PORT_OUTPUT_VALUE_ADDR, m_out);
         chk("pin_oe", m_dir, pin_oe_o);
         chk("pin_o", m_out, pin_o);
      end
      $display("test per_bit done");
      wr(PORT_DIRECTION_MASK_ADDR, 32'h0);
      repeat (3) @(posedge sys_clk_i);
      rf_unit_model_i.front_q.delete();
      rf_unit_model_i.back_q.delete();
      for (i = 0; i < 4; i++)
      begin
         seed_r = xs(seed_r);
         m_set[i] = (i < 2) ? seed_r[11:0] : {6'h0, seed_r[5:0]};
         wr(FRONT_UNIT_PHASE_ADDR + 24'(i), seed_r);
         rchk("set_rd", FRONT_UNIT_PHASE_ADDR + 24'(i), {20'h0, m_set[i]});
      end
      repeat (40) @(posedge sys_clk_i);
      got = rf_unit_model_i.front_q.size() + rf_unit_model_i.back_q.size();
      chk("idle_frames", 32'h0, got);
      rchk("status", SERIAL_STATUS_ADDR, 32'h0000000f);
      wr(MAIN_CONTROL_ADDR, 32'h00010000);
      wait_frames(4);
      for (i = 0; i < 2; i++)
      begin
         chk("front", {16'h0, i[0], 3'h0, m_set[2*i]}, rf_unit_model_i.front_q.pop_front());
         chk("back", {16'h0, i[0], 3'h0, m_set[2*i+1]}, rf_unit_model_i.back_q.pop_front());
      end
      $display("test custom done");
      wr(PORT_DIRECTION_MASK_ADDR, 32'h0000ff00);
      wr(BACK_UNIT_ATTENUATION_ADDR, 32'h15);
      wr(BACK_UNIT_ATTENUATION_ADDR, 32'h2a);
      wait_frames(2);
      chk("first", 32'h8015, rf_unit_model_i.back_q.pop_front());
      chk("resend", 32'h802a, rf_unit_model_i.back_q.pop_back());
      chk("oe_custom", 32'hf, pin_oe_o);
      $display("test resend done");
      wr(MAIN_CONTROL_ADDR, 32'h0);
      repeat (2) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk("oe_back", 32'h0000ff00, pin_oe_o);
      $display("test return done");
      complete_run();
   end
endmodule : test_dual_mode_gpio_port
bind dual_mode_gpio_port gpio_port_checker #(.PORT_W(PORT_W), .ADDR_W(ADDR_W))
   gpio_port_checker_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
   .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
   .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
